// >>> ddr_ctrl_end.sv
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy, val_ff, nxt_val, push, pop;

    assign push = in_valid && rdy_ff;
    assign pop = out_ready && val_ff;

    always_comb
    begin
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_rdy = (nxt_cnt != DEPTH[AW:0]);
        nxt_val = (nxt_cnt != '0);
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
            val_ff <= 1'b0;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            val_ff <= nxt_val;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (push)
            mem[wp_ff] <= in_data;
    end

    assign in_ready = rdy_ff;
    assign out_valid = val_ff;
    assign out_data = mem[rp_ff];
endmodule

module ddr_ctrl_end (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CKE_EN,
    input wire logic TERM_EN,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [1:0] REQ_OP,
    input wire logic [2:0] REQ_BANK,
    input wire logic [12:0] REQ_ROW,
    input wire logic [9:0] REQ_COL,
    input wire logic [31:0] REQ_DATA,
    input wire logic [3:0] REQ_MASK,
    output logic RD_VALID,
    output logic [31:0] RD_DATA,
    ddr_link_if.ctrl lk
);
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001, ST_ACT = 9'h002, ST_CMD2 = 9'h004, ST_WD0 = 9'h008, ST_WD1 = 9'h010,
        ST_WEND = 9'h020, ST_RD0 = 9'h040, ST_RD1 = 9'h080, ST_RD2 = 9'h100
    } state_e;
    state_e st_ff, nxt_st;
    logic [1:0] ph_ff, nxt_ph;
    logic ck_ff, cke_ff, nxt_cke, odt_ff, nxt_odt, diff_ff, nxt_diff;
    logic [3:0] cmd_ff, nxt_cmd;
    logic [2:0] ba_ff, nxt_ba;
    logic [12:0] addr_ff, nxt_addr;
    logic [63:0] req_ff, nxt_req, fifo_data;
    logic [15:0] dq_ff, nxt_dq, sync1_ff, sync2_ff, rd_lo_ff, nxt_rd_lo;
    logic dq_oe_ff, nxt_dq_oe, dqs_ff, nxt_dqs, rdv_ff, nxt_rdv, fifo_valid, pop;
    logic [1:0] dm_ff, nxt_dm;
    logic [31:0] rd_ff, nxt_rd;

    req_fifo #(.WIDTH(ddr_link_pkg::REQ_W), .DEPTH(ddr_link_pkg::FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .NRST(NRST),
        .in_valid(REQ_VALID),
        .in_ready(REQ_READY),
        .in_data({REQ_OP, REQ_BANK, REQ_ROW, REQ_COL, REQ_DATA, REQ_MASK}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // commands leave on the falling link edge so they are settled at the rising one
    assign pop = (st_ff == ST_IDLE) && (ph_ff == ddr_link_pkg::PH_FALL) && cke_ff && fifo_valid;

    always_comb
    begin
        nxt_ph = ph_ff + 2'h1;
        nxt_st = st_ff;
        nxt_cke = cke_ff;
        nxt_odt = odt_ff;
        nxt_diff = diff_ff;
        nxt_cmd = cmd_ff;
        nxt_ba = ba_ff;
        nxt_addr = addr_ff;
        nxt_req = req_ff;
        nxt_dq = dq_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_dqs = dqs_ff;
        nxt_dm = dm_ff;
        nxt_rd_lo = rd_lo_ff;
        nxt_rd = rd_ff;
        nxt_rdv = 1'b0;
        if (ph_ff == ddr_link_pkg::PH_FALL)
        begin
            nxt_cke = CKE_EN;
            nxt_odt = TERM_EN;
            nxt_cmd = ddr_link_pkg::CMD_NOP;
        end
        case (st_ff)
            ST_IDLE:
            begin
                if (pop)
                begin
                    nxt_req = fifo_data;
                    nxt_ba = fifo_data[61:59];
                    nxt_addr = fifo_data[58:46];
                    case (fifo_data[63:62])
                        ddr_link_pkg::OP_MODE:
                        begin
                            nxt_cmd = ddr_link_pkg::CMD_MRS;
                            if (fifo_data[61:59] == ddr_link_pkg::EMR1_BANK)
                                nxt_diff = ~fifo_data[46 + ddr_link_pkg::DIFF_OFF_BIT];
                        end
                        ddr_link_pkg::OP_PRE:
                        begin
                            nxt_cmd = ddr_link_pkg::CMD_PRE;
                            nxt_addr[ddr_link_pkg::AP_BIT] = 1'b1;
                        end
                        default:
                        begin
                            nxt_cmd = ddr_link_pkg::CMD_ACT;
                            nxt_st = ST_ACT;
                        end
                    endcase
                end
            end
            ST_ACT:
            begin
                if (ph_ff == ddr_link_pkg::PH_FALL)
                begin
                    nxt_cmd = (req_ff[63:62] == ddr_link_pkg::OP_WR) ? ddr_link_pkg::CMD_WR : ddr_link_pkg::CMD_RD;
                    nxt_addr = {2'h0, 1'b1, req_ff[45:36]};
                    nxt_st = ST_CMD2;
                end
            end
            ST_CMD2:
            begin
                if (ph_ff == ddr_link_pkg::PH_FALL)
                    nxt_st = (req_ff[63:62] == ddr_link_pkg::OP_WR) ? ST_WD0 : ST_RD0;
            end
            ST_WD0:
            begin
                if (ph_ff == ddr_link_pkg::PH_BEAT0)
                begin
                    nxt_dq = req_ff[19:4];
                    nxt_dm = req_ff[1:0];
                    nxt_dq_oe = 1'b1;
                    nxt_st = ST_WD1;
                end
            end
            ST_WD1:
            begin
                // strobe edges land a quarter period after each data change
                if (ph_ff == ddr_link_pkg::PH_RISE)
                    nxt_dqs = 1'b1;
                else if (ph_ff == ddr_link_pkg::PH_BEAT1)
                begin
                    nxt_dq = req_ff[35:20];
                    nxt_dm = req_ff[3:2];
                end
                else if (ph_ff == ddr_link_pkg::PH_FALL)
                begin
                    nxt_dqs = 1'b0;
                    nxt_st = ST_WEND;
                end
            end
            ST_WEND:
            begin
                if (ph_ff == ddr_link_pkg::PH_BEAT0)
                begin
                    nxt_dq_oe = 1'b0;
                    nxt_dm = 2'h0;
                    nxt_st = ST_IDLE;
                end
            end
            ST_RD0:
            begin
                if (ph_ff == ddr_link_pkg::PH_BEAT0)
                    nxt_st = ST_RD1;
            end
            ST_RD1:
            begin
                if (ph_ff == ddr_link_pkg::PH_BEAT0)
                begin
                    nxt_rd_lo = sync2_ff;
                    nxt_st = ST_RD2;
                end
            end
            ST_RD2:
            begin
                if (ph_ff == ddr_link_pkg::PH_BEAT1)
                begin
                    nxt_rd = {sync2_ff, rd_lo_ff};
                    nxt_rdv = 1'b1;
                    nxt_st = ST_IDLE;
                end
            end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_ff <= ST_IDLE;
            ph_ff <= 2'h0;
            ck_ff <= 1'b0;
            cke_ff <= 1'b0;
            odt_ff <= 1'b0;
            diff_ff <= 1'b1;
            cmd_ff <= ddr_link_pkg::CMD_NOP;
            ba_ff <= 3'h0;
            addr_ff <= 13'h0000;
            req_ff <= 64'h0;
            dq_ff <= 16'h0000;
            dq_oe_ff <= 1'b0;
            dqs_ff <= 1'b0;
            dm_ff <= 2'h0;
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            rd_lo_ff <= 16'h0000;
            rd_ff <= 32'h0;
            rdv_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            ph_ff <= nxt_ph;
            ck_ff <= (nxt_ph == ddr_link_pkg::PH_BEAT1) || (nxt_ph == ddr_link_pkg::PH_FALL);
            cke_ff <= nxt_cke;
            odt_ff <= nxt_odt;
            diff_ff <= nxt_diff;
            cmd_ff <= nxt_cmd;
            ba_ff <= nxt_ba;
            addr_ff <= nxt_addr;
            req_ff <= nxt_req;
            dq_ff <= nxt_dq;
            dq_oe_ff <= nxt_dq_oe;
            dqs_ff <= nxt_dqs;
            dm_ff <= nxt_dm;
            sync1_ff <= lk.dq;
            sync2_ff <= sync1_ff;
            rd_lo_ff <= nxt_rd_lo;
            rd_ff <= nxt_rd;
            rdv_ff <= nxt_rdv;
        end
    end

    assign lk.ck = ck_ff;
    assign lk.ck_n = ~ck_ff;
    assign lk.cke = cke_ff;
    assign {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} = cmd_ff;
    assign lk.termination_control = odt_ff;
    assign lk.ba = ba_ff;
    assign lk.addr = addr_ff;
    assign lk.dm = dm_ff;
    assign lk.host_dq_o = dq_ff;
    assign lk.host_dq_oe = dq_oe_ff;
    assign lk.host_dqs_o = {2{dqs_ff}};
    assign lk.host_dqs_oe = dq_oe_ff;
    assign lk.host_dqsn_oe = dq_oe_ff & diff_ff;
    assign RD_VALID = rdv_ff;
    assign RD_DATA = rd_ff;
endmodule

// >>> ddr_link_pkg.sv
package ddr_link_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 3;
    localparam int NBANKS = 8;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int BYTES = 2;
    localparam int AP_BIT = 10;
    // complementary strobes are enabled while this bit of the first extended mode register is low
    localparam int DIFF_OFF_BIT = 10;
    localparam logic [ADDR_W-1:0] EMR1_RESET = 13'h0000;
    localparam logic [BANK_W-1:0] EMR1_BANK = 3'h1;
    // command code is {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // memory kept inside the device model: index {bank, row bit 0, col[2:1], beat}
    localparam int MEM_AW = 7;
    localparam int MEM_WORDS = 128;
    // link clock is the system clock divided by four; quarter phases of the link period
    localparam logic [1:0] PH_BEAT1 = 2'h0;
    localparam logic [1:0] PH_FALL = 2'h1;
    localparam logic [1:0] PH_BEAT0 = 2'h2;
    localparam logic [1:0] PH_RISE = 2'h3;
    // request queue in front of the controller
    localparam int FIFO_DEPTH = 32;
    localparam int REQ_W = 64;
    localparam logic [1:0] OP_RD = 2'h0;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] OP_MODE = 2'h2;
    localparam logic [1:0] OP_PRE = 2'h3;
endpackage

// >>> ddr_link_if.sv
`timescale 1ns/1ps
interface ddr_link_if;
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic termination_control;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [1:0] dm;
    logic [15:0] host_dq_o;
    logic host_dq_oe;
    logic [1:0] host_dqs_o;
    logic host_dqs_oe;
    logic host_dqsn_oe;
    logic [15:0] dev_dq_o;
    logic dev_dq_oe;
    logic [1:0] dev_dqs_o;
    logic dev_dqs_oe;
    logic dev_dqsn_oe;
    logic [15:0] dq;
    logic [1:0] dqs;
    logic [1:0] dqs_n;

    // wire levels resolved from the enables; an undriven data or strobe line reads low, an undriven complement strobe reads high
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 16'h0000);
    assign dqs = dev_dqs_oe ? dev_dqs_o : (host_dqs_oe ? host_dqs_o : 2'h0);
    assign dqs_n = dev_dqsn_oe ? ~dev_dqs_o : (host_dqsn_oe ? ~host_dqs_o : 2'h3);

    modport mem (
        input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, termination_control, ba, addr, dm, dq, dqs, dqs_n,
        output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe, dev_dqsn_oe
    );
    modport ctrl (
        input dq, dqs, dqs_n,
        output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, termination_control, ba, addr, dm,
        output host_dq_o, host_dq_oe, host_dqs_o, host_dqs_oe, host_dqsn_oe
    );
endinterface

// >>> ddr_mem_end.sv
`timescale 1ns/1ps
module ddr_mem_end (
    ddr_link_if.mem lk,
    input wire logic NRST,
    output logic TERM_ON,
    output logic CLOCKING_ON,
    output logic DIFF_STROBE,
    output logic [7:0] OPEN_BANKS
);
    logic [15:0] mem [0:ddr_link_pkg::MEM_WORDS-1];
    logic [ddr_link_pkg::ADDR_W-1:0] row_ff [0:ddr_link_pkg::NBANKS-1];
    logic [ddr_link_pkg::ADDR_W-1:0] nxt_row [0:ddr_link_pkg::NBANKS-1];
    logic [7:0] open_ff, nxt_open;
    logic [12:0] emr1_ff, nxt_emr1;
    logic term_ff, clk_on_ff, diff_ff;
    logic rd_go_ff, nxt_rd_go, wr_go_ff, nxt_wr_go, commit_ff, nxt_commit, rd_hi_ff, nxt_rd_hi;
    logic [5:0] idx_ff, nxt_idx, widx_ff, nxt_widx;
    logic [15:0] wbeat0_ff, nxt_wbeat0, rbeat1_ff, nxt_rbeat1, dq_p_ff, nxt_dq_p;
    logic [1:0] wmask0_ff, nxt_wmask0;
    logic dqs_p_ff, nxt_dqs_p, oe_ff, nxt_oe;
    // falling-edge group
    logic [15:0] dq_n_ff, nxt_dq_n, wbeat1_ff, nxt_wbeat1;
    logic [1:0] wmask1_ff, nxt_wmask1;
    logic dqs_n_ff, nxt_dqs_n;
    logic [3:0] cmd;
    logic [2:0] bank;

    // keep the bytes whose mask bit is low, the old content elsewhere
    function automatic logic [15:0] merge(input logic [15:0] old_w, input logic [15:0] new_w,
                                          input logic [1:0] mask);
        logic [15:0] r;
        r = old_w;
        for (int b = 0; b < ddr_link_pkg::BYTES; b++)
        begin
            if (!mask[b])
                r[b*8 +: 8] = new_w[b*8 +: 8];
        end
        return r;
    endfunction

    assign cmd = {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n};
    assign bank = lk.ba;

    always_comb
    begin
        for (int i = 0; i < ddr_link_pkg::NBANKS; i++)
            nxt_row[i] = row_ff[i];
        nxt_open = open_ff;
        nxt_emr1 = emr1_ff;
        nxt_rd_go = 1'b0;
        nxt_wr_go = 1'b0;
        nxt_idx = idx_ff;
        nxt_widx = widx_ff;
        nxt_commit = 1'b0;
        nxt_wbeat0 = wbeat0_ff;
        nxt_wmask0 = wmask0_ff;
        nxt_rd_hi = 1'b0;
        nxt_rbeat1 = rbeat1_ff;
        nxt_dq_p = dq_p_ff;
        nxt_dqs_p = dqs_p_ff;
        nxt_oe = 1'b0;
        // commands count only while clock enable is sampled high and the rank is selected
        if (lk.cke && !lk.cs_n)
        begin
            case (cmd)
                ddr_link_pkg::CMD_ACT:
                begin
                    nxt_row[bank] = lk.addr;
                    nxt_open[bank] = 1'b1;
                end
                ddr_link_pkg::CMD_RD, ddr_link_pkg::CMD_WR:
                begin
                    // a closed bank has no row to reach, so the access is dropped
                    if (open_ff[bank])
                    begin
                        nxt_idx = {bank, row_ff[bank][0], lk.addr[2:1]};
                        nxt_rd_go = (cmd == ddr_link_pkg::CMD_RD);
                        nxt_wr_go = (cmd == ddr_link_pkg::CMD_WR);
                        if (lk.addr[ddr_link_pkg::AP_BIT])
                            nxt_open[bank] = 1'b0;
                    end
                end
                ddr_link_pkg::CMD_PRE:
                begin
                    if (lk.addr[ddr_link_pkg::AP_BIT])
                        nxt_open = 8'h00;
                    else
                        nxt_open[bank] = 1'b0;
                end
                ddr_link_pkg::CMD_MRS:
                begin
                    if (bank == ddr_link_pkg::EMR1_BANK)
                        nxt_emr1 = lk.addr;
                end
                default:
                begin
                    // refresh and no-operation leave the visible state alone
                end
            endcase
        end
        // write: first beat and its mask on the rising edge after the command
        if (wr_go_ff)
        begin
            nxt_wbeat0 = lk.dq;
            nxt_wmask0 = lk.dm;
            nxt_widx = idx_ff;
            nxt_commit = 1'b1;
        end
        // read: drive both beats inside one link period, strobe rising with the first
        if (rd_go_ff)
        begin
            nxt_oe = 1'b1;
            nxt_dq_p = mem[{idx_ff, 1'b0}] ^ dq_n_ff;
            nxt_dqs_p = ~dqs_n_ff;
            nxt_rbeat1 = mem[{idx_ff, 1'b1}];
            nxt_rd_hi = 1'b1;
        end
    end

    always_ff @(posedge lk.ck or negedge NRST)
    begin
        if (!NRST)
        begin
            for (int i = 0; i < ddr_link_pkg::NBANKS; i++)
                row_ff[i] <= 13'h0000;
            open_ff <= 8'h00;
            emr1_ff <= ddr_link_pkg::EMR1_RESET;
            term_ff <= 1'b0;
            clk_on_ff <= 1'b0;
            diff_ff <= 1'b0;
            rd_go_ff <= 1'b0;
            wr_go_ff <= 1'b0;
            idx_ff <= 6'h00;
            widx_ff <= 6'h00;
            commit_ff <= 1'b0;
            wbeat0_ff <= 16'h0000;
            wmask0_ff <= 2'h0;
            rd_hi_ff <= 1'b0;
            rbeat1_ff <= 16'h0000;
            dq_p_ff <= 16'h0000;
            dqs_p_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < ddr_link_pkg::NBANKS; i++)
                row_ff[i] <= nxt_row[i];
            open_ff <= nxt_open;
            emr1_ff <= nxt_emr1;
            term_ff <= lk.termination_control;
            clk_on_ff <= lk.cke;
            diff_ff <= ~emr1_ff[ddr_link_pkg::DIFF_OFF_BIT];
            rd_go_ff <= nxt_rd_go;
            wr_go_ff <= nxt_wr_go;
            idx_ff <= nxt_idx;
            widx_ff <= nxt_widx;
            commit_ff <= nxt_commit;
            wbeat0_ff <= nxt_wbeat0;
            wmask0_ff <= nxt_wmask0;
            rd_hi_ff <= nxt_rd_hi;
            rbeat1_ff <= nxt_rbeat1;
            dq_p_ff <= nxt_dq_p;
            dqs_p_ff <= nxt_dqs_p;
            oe_ff <= nxt_oe;
        end
    end

    // array update at the rising edge after the burst, once both beats are held
    always_ff @(posedge lk.ck)
    begin
        if (commit_ff)
        begin
            mem[{widx_ff, 1'b0}] <= merge(mem[{widx_ff, 1'b0}], wbeat0_ff, wmask0_ff);
            mem[{widx_ff, 1'b1}] <= merge(mem[{widx_ff, 1'b1}], wbeat1_ff, wmask1_ff);
        end
    end

    always_comb
    begin
        nxt_dq_n = dq_n_ff;
        nxt_dqs_n = dqs_n_ff;
        nxt_wbeat1 = wbeat1_ff;
        nxt_wmask1 = wmask1_ff;
        if (rd_hi_ff)
        begin
            nxt_dq_n = rbeat1_ff ^ dq_p_ff;
            nxt_dqs_n = dqs_p_ff;
        end
        if (commit_ff)
        begin
            nxt_wbeat1 = lk.dq;
            nxt_wmask1 = lk.dm;
        end
    end

    always_ff @(negedge lk.ck or negedge NRST)
    begin
        if (!NRST)
        begin
            dq_n_ff <= 16'h0000;
            dqs_n_ff <= 1'b0;
            wbeat1_ff <= 16'h0000;
            wmask1_ff <= 2'h0;
        end
        else
        begin
            dq_n_ff <= nxt_dq_n;
            dqs_n_ff <= nxt_dqs_n;
            wbeat1_ff <= nxt_wbeat1;
            wmask1_ff <= nxt_wmask1;
        end
    end

    // double-rate outputs as the xor of a rising and a falling flop: no clock in the data path
    assign lk.dev_dq_o = dq_p_ff ^ dq_n_ff;
    assign lk.dev_dq_oe = oe_ff;
    assign lk.dev_dqs_o = {2{dqs_p_ff ^ dqs_n_ff}};
    assign lk.dev_dqs_oe = oe_ff;
    assign lk.dev_dqsn_oe = oe_ff & diff_ff;

    assign TERM_ON = term_ff;
    assign CLOCKING_ON = clk_on_ff;
    assign DIFF_STROBE = diff_ff;
    assign OPEN_BANKS = open_ff;
endmodule

// >>> ddr_link_assertions.sv
`timescale 1ns/1ps
module ddr_link_assertions (
    input wire logic NRST,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic [1:0] dqs,
    input wire logic host_dq_oe,
    input wire logic host_dqs_oe,
    input wire logic dev_dq_oe,
    input wire logic dev_dqs_oe,
    input wire logic dev_dqsn_oe
);
    logic [3:0] cmd;
    logic acc;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign acc = cmd == ddr_link_pkg::CMD_WR || cmd == ddr_link_pkg::CMD_RD;
    // commands change at the fall, so each is seen here at the fall after the rise that takes it
    default clocking cb @(negedge ck);
    endclocking
    default disable iff (!NRST);
    sequence s_wr_beat;
        host_dq_oe && host_dqs_oe && dqs == 2'h3;
    endsequence
    sequence s_rd_beat;
        dev_dq_oe && dev_dqs_oe && dqs == 2'h3 ##1 !dev_dq_oe;
    endsequence
    property p_dq_one;
        !(host_dq_oe && dev_dq_oe);
    endproperty
    a_dq_one: assert property (p_dq_one) else $error("data lines driven from both ends");
    property p_dqs_one;
        !(host_dqs_oe && dev_dqs_oe);
    endproperty
    a_dqs_one: assert property (p_dqs_one) else $error("strobes driven from both ends");
    property p_wr_data;
        cmd == ddr_link_pkg::CMD_WR |=> s_wr_beat;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write beat missing");
    property p_rd_data;
        cmd == ddr_link_pkg::CMD_RD |=> s_rd_beat;
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read beat wrong");
    property p_act_first;
        acc |-> $past(cmd) == ddr_link_pkg::CMD_ACT && $past(ba) == ba;
    endproperty
    a_act_first: assert property (p_act_first) else $error("access without activate");
    property p_col;
        acc |-> addr[10] && addr[12:11] == 2'h0;
    endproperty
    a_col: assert property (p_col) else $error("column address bad");
    property p_pre_all;
        cmd == ddr_link_pkg::CMD_PRE |-> addr[10];
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge not all");
    property p_cke_nop;
        !cke |-> cmd == ddr_link_pkg::CMD_NOP;
    endproperty
    a_cke_nop: assert property (p_cke_nop) else $error("command with clock enable low");
    property p_table;
        !cs_n |-> cmd inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    endproperty
    a_table: assert property (p_table) else $error("command outside table");
    property p_strobe_n;
        dev_dqsn_oe |-> dev_dqs_oe;
    endproperty
    a_strobe_n: assert property (p_strobe_n) else $error("complement strobe alone");
endmodule

// >>> ddr2_sdram_pin_interface_tb.sv
`timescale 1ns/1ps
module ddr2_sdram_pin_interface_tb;
    logic CLK = 1'h0;
    logic NRST = 1'h0;
    logic cke_en = 1'h0, term_en = 1'h0, req_valid = 1'h0;
    logic [1:0] req_op = 2'h0;
    logic [2:0] req_bank = 3'h0;
    logic [12:0] req_row = 13'h0;
    logic [9:0] req_col = 10'h0;
    logic [31:0] req_data = 32'h0;
    logic [3:0] req_mask = 4'h0;
    logic req_ready, rd_valid, term_on, clocking_on, diff_strobe;
    logic [31:0] rd_data;
    logic [7:0] open_banks;
    int err_count = 0;
    int total_checks = 0;
    always #5 CLK = ~CLK;
    ddr_link_if i_ddr_link_if ();
    ddr_mem_end i_ddr_mem_end (.lk(i_ddr_link_if.mem), .NRST(NRST), .TERM_ON(term_on), .CLOCKING_ON(clocking_on),
        .DIFF_STROBE(diff_strobe), .OPEN_BANKS(open_banks));
    ddr_ctrl_end i_ddr_ctrl_end (.CLK(CLK), .NRST(NRST), .CKE_EN(cke_en), .TERM_EN(term_en), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_BANK(req_bank), .REQ_ROW(req_row), .REQ_COL(req_col),
        .REQ_DATA(req_data), .REQ_MASK(req_mask), .RD_VALID(rd_valid), .RD_DATA(rd_data), .lk(i_ddr_link_if.ctrl));
    ddr_link_assertions i_ddr_link_assertions (.NRST(NRST), .ck(i_ddr_link_if.ck), .cke(i_ddr_link_if.cke),
        .cs_n(i_ddr_link_if.cs_n), .ras_n(i_ddr_link_if.ras_n), .cas_n(i_ddr_link_if.cas_n),
        .we_n(i_ddr_link_if.we_n), .ba(i_ddr_link_if.ba), .addr(i_ddr_link_if.addr), .dqs(i_ddr_link_if.dqs),
        .host_dq_oe(i_ddr_link_if.host_dq_oe), .host_dqs_oe(i_ddr_link_if.host_dqs_oe),
        .dev_dq_oe(i_ddr_link_if.dev_dq_oe), .dev_dqs_oe(i_ddr_link_if.dev_dqs_oe),
        .dev_dqsn_oe(i_ddr_link_if.dev_dqsn_oe));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // checked at the falling edge, where registered outputs are settled
    task automatic wait_lvl(ref logic sig, input logic val);
        for (int n = 0; n < 600; n++)
        begin
            if (sig === val)
                return;
            @(negedge CLK);
        end
        err_count++;
        tally_and_finish();
    endtask
    task automatic send(input logic [1:0] op, input logic [2:0] bk, input logic [12:0] row, input logic [9:0] col,
        input logic [31:0] d, input logic [3:0] m);
        @(negedge CLK);
        req_valid = 1'h1;
        {req_op, req_bank, req_row, req_col, req_data, req_mask} = {op, bk, row, col, d, m};
        wait_lvl(req_ready, 1'h1);
        @(negedge CLK);
        req_valid = 1'h0;
    endtask
    task automatic rd(input logic [2:0] bk, input logic [31:0] exp);
        send(ddr_link_pkg::OP_RD, bk, 13'h1, 10'h4, 32'h0, 4'h0);
        wait_lvl(rd_valid, 1'h1);
        chk(rd_data, exp);
    endtask
    task automatic t_enables;
        wait_lvl(diff_strobe, 1'h1);
        chk({29'h0, term_on, clocking_on, diff_strobe}, 32'h1);
        cke_en = 1'h1;
        term_en = 1'h1;
        wait_lvl(clocking_on, 1'h1);
        wait_lvl(term_on, 1'h1);
        chk({29'h0, term_on, clocking_on, diff_strobe}, 32'h7);
        term_en = 1'h0;
        wait_lvl(term_on, 1'h0);
        chk({31'h0, term_on}, 32'h0);
    endtask
    task automatic t_rw;
        send(ddr_link_pkg::OP_WR, 3'h2, 13'h1, 10'h4, 32'h1234abcd, 4'h0);
        send(ddr_link_pkg::OP_WR, 3'h5, 13'h1, 10'h4, 32'h55aa33cc, 4'h0);
        send(ddr_link_pkg::OP_WR, 3'h2, 13'h1, 10'h4, 32'hffffffff, 4'h6);
        rd(3'h2, 32'hff34abff);
        rd(3'h5, 32'h55aa33cc);
        chk({24'h0, open_banks}, 32'h0);
    endtask
    task automatic t_mode;
        send(ddr_link_pkg::OP_MODE, 3'h0, 13'h0400, 10'h0, 32'h0, 4'h0);
        rd(3'h5, 32'h55aa33cc);
        chk({31'h0, diff_strobe}, 32'h1);
        send(ddr_link_pkg::OP_MODE, 3'h1, 13'h0400, 10'h0, 32'h0, 4'h0);
        wait_lvl(diff_strobe, 1'h0);
        rd(3'h2, 32'hff34abff);
        chk({31'h0, diff_strobe}, 32'h0);
        send(ddr_link_pkg::OP_PRE, 3'h0, 13'h0, 10'h0, 32'h0, 4'h0);
        send(ddr_link_pkg::OP_MODE, 3'h1, 13'h0000, 10'h0, 32'h0, 4'h0);
        wait_lvl(diff_strobe, 1'h1);
        chk({24'h0, open_banks}, 32'h0);
    endtask
    // pops stall while clock enable is low, so the queue fills to its depth
    task automatic t_fifo;
        int n;
        cke_en = 1'h0;
        wait_lvl(clocking_on, 1'h0);
        @(negedge CLK);
        req_valid = 1'h1;
        {req_op, req_bank, req_row, req_col, req_mask} = {ddr_link_pkg::OP_WR, 3'h3, 13'h1, 10'h4, 4'h0};
        for (n = 0; n < 40; n++)
        begin
            if (req_ready !== 1'h1)
                break;
            req_data = 32'(n);
            @(negedge CLK);
        end
        req_valid = 1'h0;
        chk(32'(n), 32'(ddr_link_pkg::FIFO_DEPTH));
        cke_en = 1'h1;
        rd(3'h3, 32'(ddr_link_pkg::FIFO_DEPTH - 1));
    endtask
    initial
    begin
        repeat (3) @(negedge CLK);
        NRST = 1'h1;
        t_enables();
        t_rw();
        t_mode();
        t_fifo();
        tally_and_finish();
    end
endmodule
